// file: hw/rds_codec_control.sv
`timescale 1ns/1ps
`default_nettype none
module rds_codec_control #(
    parameter int RX_DEPTH = 126,
    parameter int TX_BYTES = 256
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic clk_en,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Received block stream from demodulator
    input wire logic rx_stb,
    input wire rds_pkg::rx_blk_t rx_blk,
    // Audio magnitude and tuner hint
    input wire logic audio_stb,
    input wire logic [15:0] audio_mag,
    input wire logic alt_better,
    // Transmit block stream to modulator
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [25:0] tx_word,
    // Status outputs
    output logic irq,
    output logic af_retune,
    output logic [15:0] tune_chan,
    output logic sync_state
);
    import rds_pkg::*;

    // ==================== Register file
    logic [6:0] ctrl_r, ctrl_nxt;
    logic [31:0] sync_r, sync_nxt, bpat_r, bpat_nxt, pdur_r, pdur_nxt, txp_r, txp_nxt;
    logic [15:0] pi_r, pi_nxt, pthr_r, pthr_nxt, af_r, af_nxt;
    logic [IRQ_W-1:0] ist_r, ist_nxt, imask_r, imask_nxt, ev;
    logic [31:0] rdat_r, rdat_nxt;
    logic rdy_r, rdy_nxt, err_r, err_nxt, irq_r, irq_nxt;
    logic wr_done, rd_done, pop, txd_wr, mapped;
    logic [31:0] rd_mux;
    logic [6:0] cnt_r;
    logic synced_r, silent_r, busy, pause_ev;
    rx_entry_t head;

    assign wr_done = psel & penable & rdy_r & pwrite;
    assign rd_done = psel & penable & rdy_r & ~pwrite;
    assign pop = rd_done && paddr == OFS_RXD && cnt_r != 7'h00; // see R15
    assign txd_wr = wr_done && paddr == OFS_TXD;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFS_CTRL: rd_mux = {25'h0, ctrl_r};
            OFS_SYNC: rd_mux = sync_r;
            OFS_STAT: rd_mux = {15'h0, busy, 1'b0, cnt_r, 6'h0, silent_r, synced_r};
            OFS_RXD: rd_mux = {cnt_r != 7'h00, 11'h0, head.corr, head.id, head.info};
            OFS_BPAT: rd_mux = bpat_r;
            OFS_PI: rd_mux = {16'h0, pi_r};
            OFS_PTHR: rd_mux = {16'h0, pthr_r};
            OFS_PDUR: rd_mux = pdur_r;
            OFS_TXP: rd_mux = txp_r;
            OFS_TXD: rd_mux = 32'h0000_0000;
            OFS_ISTAT: rd_mux = {29'h0, ist_r};
            OFS_IMASK: rd_mux = {29'h0, imask_r};
            OFS_AF: rd_mux = {16'h0, af_r};
            default: mapped = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_nxt = ctrl_r;
        sync_nxt = sync_r;
        bpat_nxt = bpat_r;
        pi_nxt = pi_r;
        pthr_nxt = pthr_r;
        pdur_nxt = pdur_r;
        txp_nxt = txp_r;
        imask_nxt = imask_r;
        af_nxt = af_r;
        ist_nxt = ist_r | ev; // see R16
        // Answer one cycle into the access phase
        rdy_nxt = psel & penable & ~rdy_r;
        rdat_nxt = rdat_r;
        // Error flag stands only beside pready
        err_nxt = 1'b0;
        if (psel & penable & ~rdy_r) begin
            rdat_nxt = pwrite ? 32'h0000_0000 : rd_mux;
            err_nxt = ~mapped;
        end
        if (txd_wr) txp_nxt[7:0] = txp_r[7:0] + 8'h01; // see R14
        if (wr_done) begin // see R17
            case (paddr)
                OFS_CTRL: ctrl_nxt = pwdata[6:0];
                OFS_SYNC: sync_nxt = pwdata; // see R3
                OFS_BPAT: bpat_nxt = pwdata;
                OFS_PI: pi_nxt = pwdata[15:0];
                OFS_PTHR: pthr_nxt = pwdata[15:0];
                OFS_PDUR: pdur_nxt = pwdata;
                OFS_TXP: txp_nxt = pwdata;
                // Set wins: a fresh event survives its own clear
                OFS_ISTAT: ist_nxt = (ist_r & ~pwdata[IRQ_W-1:0]) | ev; // see R16
                OFS_IMASK: imask_nxt = pwdata[IRQ_W-1:0];
                OFS_AF: af_nxt = pwdata[15:0];
                default: ;
            endcase
        end
        irq_nxt = |(ist_nxt & imask_nxt);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= 7'h00;
            sync_r <= SYNC_RST;
            bpat_r <= 32'h0000_0000;
            pi_r <= 16'h0000;
            pthr_r <= PTHR_RST;
            pdur_r <= PDUR_RST;
            txp_r <= TXP_RST;
            imask_r <= 3'h0;
            ist_r <= 3'h0;
            af_r <= 16'h0000;
            rdy_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
            err_r <= 1'b0;
            irq_r <= 1'b0;
        end else if (clk_en) begin
            ctrl_r <= ctrl_nxt;
            sync_r <= sync_nxt;
            bpat_r <= bpat_nxt;
            pi_r <= pi_nxt;
            pthr_r <= pthr_nxt;
            pdur_r <= pdur_nxt;
            txp_r <= txp_nxt;
            imask_r <= imask_nxt;
            ist_r <= ist_nxt;
            af_r <= af_nxt;
            rdy_r <= rdy_nxt;
            rdat_r <= rdat_nxt;
            err_r <= err_nxt;
            irq_r <= irq_nxt;
        end
    end

    // ==================== Receive decoder and flywheel
    logic [3:0] good_r, good_nxt, bad_r, bad_nxt, run_r, run_nxt, acq_eff;
    logic synced_nxt, hit, ok, corr, store, push;
    blk_id_t exp_r, exp_nxt, hit_id, id;
    logic [9:0] s, t;
    logic [25:0] flip;
    logic [15:0] info;
    logic [6:0] wp_r, wp_nxt, rp_r, rp_nxt, cnt_nxt;
    rx_entry_t fifo [RX_DEPTH];

    function automatic blk_id_t nxt_f(input blk_id_t b);
        case (b)
            BLK_A: return BLK_B;
            BLK_B: return BLK_C;
            BLK_C, BLK_CP: return BLK_D;
            default: return BLK_A;
        endcase
    endfunction : nxt_f

    always_comb begin
        s = syn_f(rx_blk); // see R1
        acq_eff = (sync_r[3:0] < ACQ_MIN) ? ACQ_MIN : sync_r[3:0]; // see R2
        hit = 1'b0;
        hit_id = BLK_A;
        // Type E has a zero offset, so a clean syndrome finds it
        for (int k = 5; k >= 0; k--) begin
            if (s == off_f(blk_id_t'(k))) begin
                hit = 1'b1;
                hit_id = blk_id_t'(k);
            end
        end
        // Correct single-bit errors against the expected offset only, or C' where C is expected
        flip = 26'h0000000;
        corr = 1'b0;
        id = exp_r;
        if (hit && (hit_id == exp_r || (exp_r == BLK_C && hit_id == BLK_CP))) id = hit_id;
        for (int j = 0; j < 26; j++) begin
            t = s ^ syn_f(26'(1) << j);
            if (!hit && (t == off_f(exp_r) || (exp_r == BLK_C && t == off_f(BLK_CP)))) begin
                flip = 26'(1) << j; // see R1
                corr = 1'b1;
                id = (t == off_f(exp_r)) ? exp_r : BLK_CP;
            end
        end
        info = rx_blk.info ^ flip[25:10];
        ok = (hit && id == hit_id) || corr;
        good_nxt = good_r;
        bad_nxt = bad_r;
        run_nxt = run_r;
        synced_nxt = synced_r;
        exp_nxt = exp_r;
        store = 1'b0;
        if (rx_stb && ctrl_r[CTRL_RX_EN]) begin
            if (hit && hit_id == BLK_E) begin
                // Type E blocks bypass the flywheel
                store = ~ctrl_r[CTRL_E_DROP]; // see R6
                id = BLK_E;
            end else if (!synced_r) begin
                good_nxt = 4'h0;
                if (hit) begin
                    good_nxt = (good_r != 4'h0 && ok) ? good_r + 4'h1 : 4'h1; // see R2
                    exp_nxt = nxt_f(hit_id);
                    if (good_nxt >= acq_eff) begin // see R4
                        synced_nxt = 1'b1;
                        bad_nxt = 4'h0;
                        run_nxt = 4'h0;
                    end
                end
            end else begin
                exp_nxt = nxt_f(exp_r);
                if (ok) begin
                    store = ~ctrl_r[CTRL_E_ONLY]; // see R6
                    run_nxt = (run_r == 4'hF) ? run_r : run_r + 4'h1;
                    if (run_nxt >= sync_r[11:8]) bad_nxt = 4'h0; // see R3
                end else begin
                    run_nxt = 4'h0;
                    bad_nxt = bad_r + 4'h1;
                    if (bad_nxt >= sync_r[19:16]) begin // see R3
                        synced_nxt = 1'b0;
                        good_nxt = 4'h0;
                    end
                end
            end
        end
        // Full buffer drops the newest block
        push = store && cnt_r != 7'(RX_DEPTH); // see R5
        ev = 3'h0;
        ev[IRQ_PAUSE] = pause_ev; // see R9
        ev[IRQ_BMATCH] = store && id == BLK_B && ((info ^ bpat_r[15:0]) & bpat_r[31:16]) == 16'h0; // see R7
        ev[IRQ_PI] = store && (id == BLK_A || id == BLK_CP) && info == pi_r; // see R8
        wp_nxt = push ? ((wp_r == 7'(RX_DEPTH - 1)) ? 7'h00 : wp_r + 7'h01) : wp_r;
        rp_nxt = pop ? ((rp_r == 7'(RX_DEPTH - 1)) ? 7'h00 : rp_r + 7'h01) : rp_r;
        cnt_nxt = cnt_r + 7'(push) - 7'(pop);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            good_r <= 4'h0;
            bad_r <= 4'h0;
            run_r <= 4'h0;
            synced_r <= 1'b0;
            exp_r <= BLK_A;
            wp_r <= 7'h00;
            rp_r <= 7'h00;
            cnt_r <= 7'h00;
        end else if (clk_en) begin
            good_r <= good_nxt;
            bad_r <= bad_nxt;
            run_r <= run_nxt;
            synced_r <= synced_nxt;
            exp_r <= exp_nxt;
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && push) fifo[wp_r] <= '{corr, id, info}; // see R5
    end
    assign head = fifo[rp_r];

    // ==================== Audio pause detector
    logic silent_nxt, retune_r, retune_nxt;
    logic [15:0] qcnt_r, qcnt_nxt;
    logic [7:0] lcnt_r, lcnt_nxt;

    always_comb begin
        silent_nxt = silent_r;
        qcnt_nxt = qcnt_r;
        lcnt_nxt = lcnt_r;
        retune_nxt = 1'b0;
        pause_ev = 1'b0;
        if (audio_stb) begin
            if (audio_mag < pthr_r) begin
                lcnt_nxt = 8'h00;
                qcnt_nxt = (qcnt_r == 16'hFFFF) ? qcnt_r : qcnt_r + 16'h0001;
                if (!silent_r && qcnt_nxt >= pdur_r[15:0]) begin // see R9
                    silent_nxt = 1'b1;
                    pause_ev = 1'b1;
                    // Jump only inside silence to hide the retune
                    retune_nxt = ctrl_r[CTRL_AF_EN] & alt_better; // see R11
                end
            end else begin
                qcnt_nxt = 16'h0000;
                lcnt_nxt = (lcnt_r == 8'hFF) ? lcnt_r : lcnt_r + 8'h01;
                if (silent_r && lcnt_nxt >= pdur_r[23:16]) silent_nxt = 1'b0; // see R10
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            silent_r <= 1'b0;
            qcnt_r <= 16'h0000;
            lcnt_r <= 8'h00;
            retune_r <= 1'b0;
        end else if (clk_en) begin
            silent_r <= silent_nxt;
            qcnt_r <= qcnt_nxt;
            lcnt_r <= lcnt_nxt;
            retune_r <= retune_nxt;
        end
    end

    // ==================== Transmit encoder
    typedef enum logic {TX_IDLE, TX_RUN} tx_state_t;
    tx_state_t st_r, st_nxt;
    logic [7:0] txm [TX_BYTES];
    logic [1:0] blk_r, blk_nxt, mode;
    logic [7:0] grp_r, grp_nxt, scr_r, scr_nxt, rate_r, rate_nxt, b0, i0, i1;
    logic [8:0] len, p0, p1;
    logic vld_r, vld_nxt, load, last;
    logic [25:0] word_r, word_nxt;
    logic [15:0] tinfo;
    blk_id_t tid;

    assign mode = ctrl_r[CTRL_MODE +: 2];
    assign len = txp_r[16:8];
    assign busy = st_r == TX_RUN;

    always_comb begin
        st_nxt = st_r;
        blk_nxt = blk_r;
        grp_nxt = grp_r;
        scr_nxt = scr_r;
        rate_nxt = rate_r;
        vld_nxt = vld_r;
        word_nxt = word_r;
        load = (st_r == TX_RUN) && (!vld_r || tx_ready);
        // Service name window, wrapped once; needs at least six bytes
        p0 = {1'b0, scr_r} + {6'h0, grp_r[1:0], 1'b0};
        if (p0 >= len) p0 = p0 - len;
        p1 = p0 + 9'h001;
        if (p1 >= len) p1 = 9'h000;
        i0 = p0[7:0];
        i1 = p1[7:0];
        b0 = (mode == MODE_RAW) ? {grp_r[4:0], blk_r, 1'b0} : {grp_r[5:0], 2'b00}; // see R12
        tid = blk_id_t'(blk_r == 2'h3 ? BLK_D : {1'b0, blk_r});
        tinfo = pi_r;
        if (mode == MODE_RAW) begin
            tinfo = {txm[b0], txm[b0 + 8'h01]};
        end else if (blk_r == 2'h1) begin
            tinfo = (mode == MODE_PS) ? {4'h0, 1'b1, 9'h000, grp_r[1:0]} :
                                        {4'h2, 8'h00, grp_r[3:0]};
        end else if (blk_r == 2'h2) begin
            if (mode == MODE_PS) tid = BLK_CP;
            else tinfo = {txm[b0], txm[b0 + 8'h01]};
        end else if (blk_r == 2'h3) begin
            tinfo = (mode == MODE_PS) ? {txm[i0], txm[i1]} : {txm[b0 + 8'h02], txm[b0 + 8'h03]};
        end
        case (mode)
            MODE_RAW: last = {grp_r, 3'b000} + 11'h008 >= {2'b00, len};
            MODE_PS: last = grp_r[1:0] == 2'h3;
            default: last = {grp_r, 2'b00} + 10'h004 >= {1'b0, len} || grp_r == 8'h0F;
        endcase
        case (st_r)
            TX_IDLE: begin
                blk_nxt = 2'h0;
                grp_nxt = 8'h00;
                if (ctrl_r[CTRL_TX_EN] && len != 9'h000) st_nxt = TX_RUN; // see R17
            end
            TX_RUN: begin
                if (tx_ready) vld_nxt = 1'b0;
                if (!ctrl_r[CTRL_TX_EN]) begin
                    if (!vld_r || tx_ready) st_nxt = TX_IDLE;
                end else if (load) begin
                    vld_nxt = 1'b1;
                    word_nxt = {tinfo, syn_f({tinfo, 10'h000}) ^ off_f(tid)}; // see R12
                    blk_nxt = blk_r + 2'h1;
                    if (blk_r == 2'h3) begin
                        grp_nxt = last ? 8'h00 : grp_r + 8'h01;
                        if (last && mode == MODE_PS) begin
                            rate_nxt = rate_r + 8'h01;
                            if (rate_nxt >= txp_r[31:24]) begin // see R13
                                rate_nxt = 8'h00;
                                scr_nxt = ({1'b0, scr_r} + 9'h001 >= len) ? 8'h00 : scr_r + 8'h01;
                            end
                        end
                    end
                end
            end
            default: st_nxt = TX_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= TX_IDLE;
            blk_r <= 2'h0;
            grp_r <= 8'h00;
            scr_r <= 8'h00;
            rate_r <= 8'h00;
            vld_r <= 1'b0;
            word_r <= 26'h0000000;
        end else if (clk_en) begin
            st_r <= st_nxt;
            blk_r <= blk_nxt;
            grp_r <= grp_nxt;
            scr_r <= scr_nxt;
            rate_r <= rate_nxt;
            vld_r <= vld_nxt;
            word_r <= word_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (clk_en && txd_wr) txm[txp_r[7:0]] <= pwdata[7:0]; // see R14
    end

    // ==================== Outputs
    assign prdata = rdat_r;
    assign pready = rdy_r;
    assign pslverr = err_r;
    assign irq = irq_r;
    assign tx_valid = vld_r;
    assign tx_word = word_r;
    assign af_retune = retune_r;
    assign tune_chan = af_r;
    assign sync_state = synced_r;
endmodule : rds_codec_control
`default_nettype wire

// file: hw/rds_pkg.sv
// How it works
// R1 - Received blocks are checked by syndrome, single-bit errors are corrected, and block position is tracked.
// R2 - Sync is declared after a set number of consecutive error-free blocks, which may be as low as two.
// R3 - Separate settings govern acquiring sync, keeping it, and declaring it lost.
// R4 - The good-block count needed for sync is held in a register.
// R5 - Decoded blocks are queued for the host in a buffer of 126 entries.
// R6 - Blocks are filtered before queuing, and type E blocks can be dropped or selected alone.
// R7 - Each queued block B is compared with a masked pattern, and a match raises an interrupt.
// R8 - A program identifier equal to the configured value raises an interrupt.
// R9 - Audio held below a threshold for a set number of samples raises an interrupt.
// R10 - Silence and presence are each declared only after a run of consistent samples.
// R11 - With jump enabled, a pause on a better alternate channel requests a retune.
// R12 - Transmit sends raw stored blocks, or builds radio text or service name groups.
// R13 - Service name mode scrolls the text at a programmable rate.
// R14 - Transmit data lives in a 256-byte store.
// R15 - Receive data is read and transmit data written over the host register port.
// R16 - Each interrupt cause sets its own flag, held until the host clears it.
// R17 - The device acts on host commands given through its registers.
package rds_pkg;
    // ==================== Register map
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SYNC = 8'h04;
    localparam logic [7:0] OFS_STAT = 8'h08;
    localparam logic [7:0] OFS_RXD = 8'h0C;
    localparam logic [7:0] OFS_BPAT = 8'h10;
    localparam logic [7:0] OFS_PI = 8'h14;
    localparam logic [7:0] OFS_PTHR = 8'h18;
    localparam logic [7:0] OFS_PDUR = 8'h1C;
    localparam logic [7:0] OFS_TXP = 8'h20;
    localparam logic [7:0] OFS_TXD = 8'h24;
    localparam logic [7:0] OFS_ISTAT = 8'h28;
    localparam logic [7:0] OFS_IMASK = 8'h2C;
    localparam logic [7:0] OFS_AF = 8'h30;
    // ==================== Fields
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_TX_EN = 1;
    localparam int CTRL_MODE = 2;
    localparam int CTRL_E_DROP = 4;
    localparam int CTRL_E_ONLY = 5;
    localparam int CTRL_AF_EN = 6;
    localparam int IRQ_BMATCH = 0;
    localparam int IRQ_PI = 1;
    localparam int IRQ_PAUSE = 2;
    localparam int IRQ_W = 3;
    localparam logic [1:0] MODE_RAW = 2'h0;
    localparam logic [1:0] MODE_RT = 2'h1;
    localparam logic [1:0] MODE_PS = 2'h2;
    // ==================== Reset values
    localparam logic [31:0] SYNC_RST = 32'h0004_0202;
    localparam logic [15:0] PTHR_RST = 16'h0100;
    localparam logic [31:0] PDUR_RST = 32'h0010_0400;
    localparam logic [31:0] TXP_RST = 32'h0001_0000;
    localparam logic [3:0] ACQ_MIN = 4'h2;
    // ==================== Code constants
    localparam logic [10:0] GEN_POLY = 11'h5B9;
    typedef enum logic [2:0] {BLK_A, BLK_B, BLK_C, BLK_CP, BLK_D, BLK_E} blk_id_t;
    typedef struct packed {
        logic [15:0] info;
        logic [9:0] check;
    } rx_blk_t;
    typedef struct packed {
        logic corr;
        blk_id_t id;
        logic [15:0] info;
    } rx_entry_t;

    function automatic logic [9:0] syn_f(input logic [25:0] w);
        logic [10:0] s;
        s = 11'h000;
        for (int i = 25; i >= 0; i--) begin
            s = {s[9:0], w[i]};
            if (s[10]) s = s ^ GEN_POLY;
        end
        return s[9:0];
    endfunction : syn_f

    function automatic logic [9:0] off_f(input blk_id_t id);
        case (id)
            BLK_A: return 10'h0FC;
            BLK_B: return 10'h198;
            BLK_C: return 10'h168;
            BLK_CP: return 10'h350;
            BLK_D: return 10'h1B4;
            default: return 10'h000;
        endcase
    endfunction : off_f
endpackage : rds_pkg

// file: verif/rds_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rds_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Streams and status
    input wire logic rx_stb,
    input wire logic audio_stb,
    input wire logic alt_better,
    input wire logic tx_ready,
    input wire logic tx_valid,
    input wire logic [25:0] tx_word,
    input wire logic af_retune,
    input wire logic sync_state
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========
    // Host port
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready held too long");
    AST_ERR_QUAL: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_READY_CAUSE: assert property (pready |-> $past(psel && penable))
        else $error("pready without access");
    AST_ACCESS_ANSWER: assert property (psel && penable && !pready |-> ##[0:2] pready)
        else $error("access not answered");
    // ==========
    // Streams and status
    AST_TX_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
        else $error("tx word changed while stalled");
    AST_TX_NO_DROP: assert property ($fell(tx_valid) |-> $past(tx_ready))
        else $error("tx word dropped");
    AST_RETUNE_PULSE: assert property (af_retune |=> !af_retune)
        else $error("retune not a pulse");
    AST_RETUNE_CAUSE: assert property (af_retune |-> $past(audio_stb) && $past(alt_better))
        else $error("retune without cause");
    AST_SYNC_CAUSE: assert property ($rose(sync_state) |-> $past(rx_stb))
        else $error("sync without block");
endmodule : rds_monitor
bind rds_codec_control rds_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .rx_stb(rx_stb),
    .audio_stb(audio_stb), .alt_better(alt_better), .tx_ready(tx_ready),
    .tx_valid(tx_valid), .tx_word(tx_word), .af_retune(af_retune), .sync_state(sync_state));
`default_nettype wire

// file: verif/rds_mod_sink.sv
`timescale 1ns/1ps
`default_nettype none
module rds_mod_sink (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Block stream
    input wire logic tx_valid,
    input wire logic [25:0] tx_word,
    output logic tx_ready,
    // Capture
    output logic [25:0] word0,
    output logic [25:0] word1,
    output logic [7:0] n_words
);
    // Stalls every other cycle to exercise the hold
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_ready <= 1'b0;
            n_words <= 8'h00;
        end else begin
            tx_ready <= ~tx_ready;
            if (tx_valid && tx_ready) begin
                if (n_words == 8'h00) word0 <= tx_word;
                if (n_words == 8'h01) word1 <= tx_word;
                n_words <= n_words + 8'h01;
            end
        end
    end
endmodule : rds_mod_sink
`default_nettype wire

// file: verif/rds_codec_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rds_codec_control_tb;
    import rds_pkg::*;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, rerr, rx_stb = 0, audio_stb = 0, alt_better = 1;
    logic tx_ready, tx_valid, irq, af_retune, sync_state;
    logic [25:0] rx_blk = 26'h0, tx_word, w0, w1, last_e;
    logic [15:0] audio_mag = 16'h0, tune_chan;
    logic [7:0] nw;
    int num_errors = 0, num_checks = 0, n_ret = 0;
    rds_codec_control DUT (.sys_clk(sys_clk), .rstn(rstn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_stb(rx_stb),
        .rx_blk(rx_blk), .audio_stb(audio_stb), .audio_mag(audio_mag),
        .alt_better(alt_better), .tx_ready(tx_ready), .tx_valid(tx_valid),
        .tx_word(tx_word), .irq(irq), .af_retune(af_retune), .tune_chan(tune_chan),
        .sync_state(sync_state));
    rds_mod_sink u_sink (.sys_clk(sys_clk), .rstn(rstn), .tx_valid(tx_valid),
        .tx_word(tx_word), .tx_ready(tx_ready), .word0(w0), .word1(w1), .n_words(nw));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (af_retune === 1'b1) n_ret++;
    // ==========
    // Helpers
    function automatic logic [9:0] chk(input logic [15:0] d);
        logic [25:0] r;
        r = {d, 10'h000};
        for (int i = 25; i >= 10; i--) if (r[i]) r[i-:11] = r[i-:11] ^ 11'h5B9;
        return r[9:0];
    endfunction : chk
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        cmp(nm, e, rdat);
    endtask : rdc
    task automatic blk(input logic [15:0] d, input logic [9:0] ofs);
        @(posedge sys_clk);
        rx_stb <= 1'b1;
        rx_blk <= {d, chk(d) ^ ofs};
        @(posedge sys_clk);
        rx_stb <= 1'b0;
    endtask : blk
    task automatic aud(input logic [15:0] m);
        @(posedge sys_clk);
        audio_stb <= 1'b1;
        audio_mag <= m;
        @(posedge sys_clk);
        audio_stb <= 1'b0;
    endtask : aud
    task automatic report_and_stop;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : report_and_stop
    initial begin
        #500000;
        num_errors++;
        report_and_stop();
    end
    // ==========
    // Tests
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        rdc("sync", OFS_SYNC, SYNC_RST);
        rdc("pthr", OFS_PTHR, 32'h0000_0100);
        rdc("pdur", OFS_PDUR, PDUR_RST);
        rdc("txp", OFS_TXP, TXP_RST);
        apb(1'b0, 8'h40, 32'h0);
        cmp("unmapped err", 32'h1, {31'h0, rerr});
        apb(1'b1, OFS_SYNC, 32'h0004_0202);
        apb(1'b1, OFS_BPAT, 32'hFFFF_2400);
        apb(1'b1, OFS_PI, 32'h0000_5A5A);
        apb(1'b1, OFS_IMASK, 32'h0000_0007);
        apb(1'b1, OFS_CTRL, 32'h0000_0041);
        repeat (3) begin
            blk(16'h5A5A, 10'h0FC);
            blk(16'h2400, 10'h198);
            blk(16'h1234, 10'h168);
            blk(16'hBEEF, 10'h1B4);
        end
        cmp("sync_state", 32'h1, {31'h0, sync_state});
        rdc("istat rx", OFS_ISTAT, 32'h3);
        cmp("irq rx", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_ISTAT, 32'h3);
        rdc("istat clr", OFS_ISTAT, 32'h0);
        last_e = 26'h0;
        for (int i = 0; i < 130; i++) begin
            apb(1'b0, OFS_RXD, 32'h0);
            if (rdat[31] !== 1'b1) break;
            last_e = {rdat[18:16], rdat[15:0], 7'h0};
        end
        cmp("last entry", {3'h4, 16'hBEEF, 7'h0}, last_e);
        blk(16'hE0E0, 10'h000);
        rdc("e kept", OFS_RXD, 32'h8005_E0E0);
        apb(1'b1, OFS_CTRL, 32'h0000_0051);
        blk(16'hE0E0, 10'h000);
        apb(1'b0, OFS_RXD, 32'h0);
        cmp("e dropped", 32'h0, {31'h0, rdat[31]});
        // Pause: 4 quiet samples, 2 loud to return
        apb(1'b1, OFS_PDUR, 32'h0002_0004);
        apb(1'b1, OFS_AF, 32'h0000_1357);
        repeat (5) aud(16'h00FF);
        rdc("istat pause", OFS_ISTAT, 32'h4);
        cmp("retunes", 32'h1, n_ret);
        cmp("tune_chan", 32'h1357, tune_chan);
        apb(1'b0, OFS_STAT, 32'h0);
        cmp("silent", 32'h1, rdat[1]);
        aud(16'h0100);
        aud(16'h0100);
        apb(1'b0, OFS_STAT, 32'h0);
        cmp("present", 32'h0, rdat[1]);
        // Raw transmit from the store
        apb(1'b1, OFS_TXP, 32'h0000_0800);
        for (int i = 0; i < 8; i++) apb(1'b1, OFS_TXD, 32'h11 * (i + 1));
        apb(1'b1, OFS_CTRL, 32'h0000_0003);
        for (int i = 0; i < 400 && nw < 8'h02; i++) @(posedge sys_clk);
        cmp("tx A", {16'h1122, chk(16'h1122) ^ 10'h0FC}, w0);
        cmp("tx B", {16'h3344, chk(16'h3344) ^ 10'h198}, w1);
        report_and_stop();
    end
endmodule : rds_codec_control_tb
`default_nettype wire
